// [hdl/prs_pkg.sv]
// constants and types shared by the program register set
package prs_pkg;
    // ------------------------------------------------------------------
    // widths and indices
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned REG_COUNT    = 32;
    localparam int unsigned IDX_W        = 5;
    localparam int unsigned PC_W         = 26;
    localparam int unsigned PC_TOP_LSB   = 26;
    localparam int unsigned SHAMT_W      = 5;
    localparam int unsigned STAGES       = 5;
    localparam int unsigned DADDR_W      = 32;
    localparam int unsigned BITSEL_W     = 3;
    localparam logic [4:0]  ZERO_IDX     = 5'h00;
    localparam logic [4:0]  EBASE_IDX    = 5'h1e;
    localparam logic [31:0] PC_RESET     = 32'h00000000;
    localparam logic [31:0] REG_RESET    = 32'h00000000;
    localparam logic [25:0] PC_STEP      = 26'h0000004;
    localparam logic [25:0] PC_EVEN_MASK = 26'h3fffffe;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRS_BIT_SET    = 2'h0,
        PRS_BIT_CLEAR  = 2'h1,
        PRS_BIT_INVERT = 2'h2,
        PRS_BIT_TEST   = 2'h3
    } prs_bitop_t;

    typedef enum logic [1:0] {
        PRS_SH_LEFT  = 2'h0,
        PRS_SH_RIGHT = 2'h1,
        PRS_SH_ARITH = 2'h2,
        PRS_SH_NONE  = 2'h3
    } prs_shop_t;

    typedef enum logic [1:0] {
        PRS_PC_STEP   = 2'h0,
        PRS_PC_BRANCH = 2'h1,
        PRS_PC_JUMP   = 2'h3,
        PRS_PC_HOLD   = 2'h2
    } prs_pcop_t;

    // ------------------------------------------------------------------
    // shared arithmetic
    // ------------------------------------------------------------------
    // carry out of bit 25 drops off; bit 0 forced clear
    function automatic logic [25:0] pc_wrap(input logic [25:0] a,
                                            input logic [25:0] b);
        logic [25:0] s;
        s = a + b;
        return s & PC_EVEN_MASK;
    endfunction

    function automatic logic [31:0] pc_extend(input logic [25:0] p);
        return {6'h00, p};
    endfunction
endpackage

// [hdl/prs_shifter.sv]
// single-cycle barrel shifter and single-bit operation unit
`timescale 1ns/100ps
module prs_shifter (
    input  wire logic [31:0] sh_data,
    input  wire logic [4:0]  sh_amount,
    input  wire logic [1:0]  sh_op,
    input  wire logic [7:0]  bit_byte,
    input  wire logic [2:0]  bit_sel,
    input  wire logic [1:0]  bit_op,
    output logic      [31:0] sh_result,
    output logic      [7:0]  bit_result,
    output logic             bit_was_zero
);
    // ------------------------------------------------------------------
    // shift
    // ------------------------------------------------------------------
    // pure combinational: any amount costs one cycle
    always_comb begin
        case (prs_pkg::prs_shop_t'(sh_op))
            prs_pkg::PRS_SH_LEFT:  sh_result = sh_data << sh_amount;
            prs_pkg::PRS_SH_RIGHT: sh_result = sh_data >> sh_amount;
            prs_pkg::PRS_SH_ARITH:
                sh_result = $unsigned($signed(sh_data) >>> sh_amount);
            default:               sh_result = sh_data;
        endcase
    end

    // ------------------------------------------------------------------
    // bit operations
    // ------------------------------------------------------------------
    logic [7:0] one_hot;
    assign one_hot      = 8'h01 << bit_sel;
    assign bit_was_zero = ~|(bit_byte & one_hot);

    always_comb begin
        case (prs_pkg::prs_bitop_t'(bit_op))
            prs_pkg::PRS_BIT_SET:    bit_result = bit_byte | one_hot;
            prs_pkg::PRS_BIT_CLEAR:  bit_result = bit_byte & ~one_hot;
            prs_pkg::PRS_BIT_INVERT: bit_result = bit_byte ^ one_hot;
            default:                 bit_result = bit_byte;
        endcase
    end
endmodule // prs_shifter

// [hdl/prs_pc_unit.sv]
// program counter next-value logic
`timescale 1ns/100ps
module prs_pc_unit (
    input  wire logic [25:0] pc_now,
    input  wire logic [1:0]  pc_op,
    input  wire logic [25:0] pc_offset,
    input  wire logic [31:0] pc_target,
    output logic      [25:0] pc_next
);
    // ------------------------------------------------------------------
    // next pc
    // ------------------------------------------------------------------
    always_comb begin
        case (prs_pkg::prs_pcop_t'(pc_op))
            prs_pkg::PRS_PC_STEP:
                pc_next = prs_pkg::pc_wrap(pc_now, prs_pkg::PC_STEP);
            prs_pkg::PRS_PC_BRANCH:
                pc_next = prs_pkg::pc_wrap(pc_now, pc_offset);
            prs_pkg::PRS_PC_JUMP:
                // upper target bits fall outside the 64 MB program space
                pc_next = pc_target[25:0] & prs_pkg::PC_EVEN_MASK;
            default:
                pc_next = pc_now;
        endcase
    end
endmodule // prs_pc_unit

// [hdl/prs_regset.sv]
// program register set: general registers, program counter, shift and bit ops
//
// Functional notes
// - thirty-two 32-bit registers serve as data or address operands.
// - index zero always reads as zero.
// - index thirty supplies the base for short-format load and store.
// - the pc keeps 26 bits and bits 31 to 26 read as zero.
// - a carry out of pc bit 25 is discarded so the pc wraps.
// - pc bit 0 is held at zero so no odd target exists.
// - a five-stage pipeline retires about one instruction per cycle.
// - fetch spans a 64 MB space and data spans a 4 GB space.
// - a full 32-bit shift completes in one cycle for any amount.
// - bit set, clear, invert and test are supported on a target bit.
`timescale 1ns/100ps
module prs_regset (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        stall,
    input  wire logic [4:0]  rd_a_idx,
    input  wire logic [4:0]  rd_b_idx,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic        issue_valid,
    input  wire logic        short_format_load,
    input  wire logic        short_format_store,
    input  wire logic [7:0]  short_disp,
    input  wire logic        sh_valid,
    input  wire logic [1:0]  sh_op,
    input  wire logic [4:0]  sh_amount,
    input  wire logic        bit_valid,
    input  wire logic [1:0]  bit_op,
    input  wire logic [2:0]  bit_sel,
    input  wire logic [7:0]  bit_byte,
    input  wire logic [1:0]  pc_op,
    input  wire logic [25:0] pc_offset,
    input  wire logic [31:0] pc_target,
    output logic      [31:0] rd_a_data,
    output logic      [31:0] rd_b_data,
    output logic      [31:0] pc_value,
    output logic      [25:0] fetch_addr,
    output logic      [31:0] short_addr,
    output logic             short_valid,
    output logic      [31:0] sh_result,
    output logic             sh_done,
    output logic      [7:0]  bit_result,
    output logic             bit_zero_flag,
    output logic             bit_done,
    output logic             retire_valid
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [prs_pkg::REG_COUNT-1:0][31:0] regs;
        logic [25:0]                         pc;
        logic [31:0]                         rd_a;
        logic [31:0]                         rd_b;
        logic [31:0]                         saddr;
        logic                                svalid;
        logic [31:0]                         shres;
        logic                                shdone;
        logic [7:0]                          bres;
        logic                                bzero;
        logic                                bdone;
        logic [prs_pkg::STAGES-1:0]          pipe;
    } prs_state_t;

    prs_state_t st_q;
    prs_state_t st_d;

    logic [25:0] pc_next;
    logic [31:0] sh_comb;
    logic [7:0]  bit_comb;
    logic        bit_zero_comb;

    // ------------------------------------------------------------------
    // leaves
    // ------------------------------------------------------------------
    prs_pc_unit u_pc (
        .pc_now    (st_q.pc),
        .pc_op     (pc_op),
        .pc_offset (pc_offset),
        .pc_target (pc_target),
        .pc_next   (pc_next)
    );

    // shift operand comes from port a read in the same cycle
    prs_shifter u_sh (
        .sh_data      (read_reg(st_q.regs, rd_a_idx)),
        .sh_amount    (sh_amount),
        .sh_op        (sh_op),
        .bit_byte     (bit_byte),
        .bit_sel      (bit_sel),
        .bit_op       (bit_op),
        .sh_result    (sh_comb),
        .bit_result   (bit_comb),
        .bit_was_zero (bit_zero_comb)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // write-through so the pipeline sees a same-cycle result
    function automatic logic [31:0] read_reg(
        input logic [prs_pkg::REG_COUNT-1:0][31:0] r,
        input logic [4:0] idx);
        if (idx == prs_pkg::ZERO_IDX) begin
            return 32'h00000000;
        end
        if (wr_en && wr_idx == idx) begin
            return wr_data;
        end
        return r[idx];
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rd_a = read_reg(st_q.regs, rd_a_idx);
        st_d.rd_b = read_reg(st_q.regs, rd_b_idx);
        if (wr_en && wr_idx != prs_pkg::ZERO_IDX) begin
            st_d.regs[wr_idx] = wr_data;
        end
        st_d.regs[prs_pkg::ZERO_IDX] = prs_pkg::REG_RESET;
        // base is full 32 bits: data space is the whole 4 GB
        st_d.saddr = read_reg(st_q.regs, prs_pkg::EBASE_IDX)
                   + {24'h000000, short_disp};
        st_d.svalid = short_format_load | short_format_store;
        st_d.shdone = sh_valid;
        if (sh_valid) begin
            st_d.shres = sh_comb;
        end
        st_d.bdone = bit_valid;
        if (bit_valid) begin
            st_d.bres  = bit_comb;
            st_d.bzero = bit_zero_comb;
        end
        // stall freezes fetch and the pipe; otherwise one slot per cycle
        if (!stall) begin
            st_d.pc   = pc_next;
            st_d.pipe = {st_q.pipe[prs_pkg::STAGES-2:0], issue_valid};
        end
        st_d.pc = st_d.pc & prs_pkg::PC_EVEN_MASK;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.pc <= prs_pkg::PC_RESET[25:0];
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_a_data     = st_q.rd_a;
    assign rd_b_data     = st_q.rd_b;
    assign pc_value      = prs_pkg::pc_extend(st_q.pc);
    assign fetch_addr    = st_q.pc;
    assign short_addr    = st_q.saddr;
    assign short_valid   = st_q.svalid;
    assign sh_result     = st_q.shres;
    assign sh_done       = st_q.shdone;
    assign bit_result    = st_q.bres;
    assign bit_zero_flag = st_q.bzero;
    assign bit_done      = st_q.bdone;
    assign retire_valid  = st_q.pipe[prs_pkg::STAGES-1];
endmodule // prs_regset

// [verification/prs_pipe_model.sv]
// writeback-side partner: mirror of what the pipeline has written back
`timescale 1ns/100ps
module prs_pipe_model (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        wr_en,
    input wire logic [4:0]  wr_idx,
    input wire logic [31:0] wr_data
);
    // ------------------------------------------------------------------
    // register mirror
    // ------------------------------------------------------------------
    // entry zero is never written, so it stays zero for every reader
    logic [31:0] mirror [32];

    always @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < 32; i++) begin
                mirror[i] <= 32'h00000000;
            end
        end else if (wr_en && wr_idx != 5'h00) begin
            mirror[wr_idx] <= wr_data;
        end
    end
endmodule // prs_pipe_model

// [verification/prs_regset_props.sv]
// concurrent checks on the program register set ports
`timescale 1ns/100ps
module prs_regset_props (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        stall,
    input wire logic [4:0]  rd_a_idx,
    input wire logic        issue_valid,
    input wire logic        short_format_load,
    input wire logic        short_format_store,
    input wire logic        sh_valid,
    input wire logic        bit_valid,
    input wire logic [1:0]  pc_op,
    input wire logic [31:0] pc_target,
    input wire logic [31:0] rd_a_data,
    input wire logic [31:0] pc_value,
    input wire logic [25:0] fetch_addr,
    input wire logic        short_valid,
    input wire logic        sh_done,
    input wire logic        bit_done,
    input wire logic        retire_valid
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_zero_read: assert property (rd_a_idx == 5'h00 |=>
        rd_a_data == 32'h0)
        else $error("index zero read nonzero");
    a_pc_top_zero: assert property (pc_value[31:26] == 6'h00)
        else $error("pc upper bits nonzero");
    a_pc_even: assert property (!fetch_addr[0] && !pc_value[0])
        else $error("pc odd");
    a_pc_fetch_match: assert property (pc_value[25:0] == fetch_addr)
        else $error("pc and fetch address differ");
    a_pc_step_wrap: assert property (!stall && pc_op == 2'h0 |=>
        fetch_addr == (($past(fetch_addr) + 26'h4) & 26'h3fffffe))
        else $error("pc step wrong");
    a_pc_jump_even: assert property (!stall && pc_op == 2'h3 |=>
        {6'h00, fetch_addr} == ($past(pc_target) & 32'h03fffffe))
        else $error("pc jump wrong");
    a_short_answer: assert property (short_format_load || short_format_store
        |=> short_valid)
        else $error("short address not answered");
    a_shift_one_cycle: assert property (sh_valid |=> sh_done)
        else $error("shift not done in one cycle");
    a_bit_one_cycle: assert property (bit_valid |=> bit_done)
        else $error("bit op not done");
    a_retire_five: assert property ((issue_valid && !stall) ##1
        (!stall) [*4] |=> retire_valid)
        else $error("retire not after five stages");
endmodule // prs_regset_props

bind prs_regset prs_regset_props u_props (.*);

// [verification/prs_regset_tb_top.sv]
// self-checking bench for the program register set
`timescale 1ns/100ps
module prs_regset_tb_top;
    // ------------------------------------------------------------------
    // signals, design and partner
    // ------------------------------------------------------------------
    logic        clk = 1'b0, srst = 1'b1, stall = 1'b0, wr_en = 1'b0;
    logic        issue_valid = 1'b0, short_format_load = 1'b0;
    logic        short_format_store = 1'b0, sh_valid = 1'b0, bit_valid = 1'b0;
    logic [4:0]  rd_a_idx = 5'h00, rd_b_idx = 5'h00, wr_idx = 5'h00;
    logic [4:0]  sh_amount = 5'h00;
    logic [1:0]  sh_op = 2'h3, bit_op = 2'h3, pc_op = 2'h2;
    logic [2:0]  bit_sel = 3'h0;
    logic [7:0]  short_disp = 8'h00, bit_byte = 8'h00, bit_result;
    logic [25:0] pc_offset = 26'h0, fetch_addr;
    logic [31:0] wr_data = 32'h0, pc_target = 32'h0, rd_a_data, rd_b_data;
    logic [31:0] pc_value, short_addr, sh_result;
    logic        short_valid, sh_done, bit_zero_flag, bit_done, retire_valid;
    int          error_cnt = 0, samples_checked = 0;

    prs_regset dut (.*);
    prs_pipe_model pm (.*);
    always #5 clk = ~clk;

    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr_one(logic [4:0] i, logic [31:0] d);
        wr_en = 1'b1;
        wr_idx = i;
        wr_data = d;
        tick();
        wr_en = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // back-to-back writes to every index, zero included, then cross reads
    task automatic t_regs();
        wr_en = 1'b1;
        for (int i = 0; i < 32; i++) begin
            wr_idx = i[4:0];
            wr_data = 32'h5a000000 + 32'(i);
            tick();
        end
        wr_en = 1'b0;
        for (int i = 0; i < 32; i++) begin
            rd_a_idx = i[4:0];
            rd_b_idx = 5'h1f - i[4:0];
            tick();
            check("rd_a_data", rd_a_data, pm.mirror[i]);
            check("rd_b_data", rd_b_data, pm.mirror[31 - i]);
        end
        check("zero_store", dut.st_q.regs[0], 32'h0);
        // same-cycle write and read of one index must bypass
        wr_en = 1'b1;
        wr_idx = 5'h07;
        wr_data = 32'hc3c3c3c3;
        rd_a_idx = 5'h07;
        tick();
        check("rd_bypass", rd_a_data, 32'hc3c3c3c3);
        wr_en = 1'b0;
        tick();
    endtask
    task automatic t_short();
        wr_one(prs_pkg::EBASE_IDX, 32'h0000fff0);
        short_format_load = 1'b1;
        short_disp = 8'hff;
        tick();
        short_format_load = 1'b0;
        short_format_store = 1'b1;
        short_disp = 8'h10;
        check("short_addr", short_addr, 32'h000100ef);
        tick();
        short_format_store = 1'b0;
        check("short_addr", short_addr, 32'h00010000);
        check("short_valid", {31'h0, short_valid}, 32'h1);
    endtask
    task automatic t_pc();
        pc_target = 32'hfffffffd;
        pc_op = 2'h3;
        tick();
        check("pc_value", pc_value, 32'h03fffffc);
        pc_op = 2'h0;
        tick();
        check("pc_value", pc_value, 32'h0);
        pc_op = 2'h1;
        pc_offset = 26'h3fffff1;
        tick();
        check("pc_value", pc_value, 32'h03fffff0);
        pc_offset = 26'h0000013;
        tick();
        pc_op = 2'h2;
        check("pc_value", pc_value, 32'h2);
        tick();
        check("fetch_addr", {6'h00, fetch_addr}, 32'h2);
    endtask
    // all four shift kinds at the widest amount, held valid back to back
    task automatic t_shift();
        logic [31:0] exp [4] = '{32'h80000000, 32'h1, 32'hffffffff,
                                 32'h80000001};
        wr_one(5'h05, 32'h80000001);
        rd_a_idx = 5'h05;
        sh_amount = 5'h1f;
        sh_valid = 1'b1;
        for (int k = 0; k < 4; k++) begin
            sh_op = k[1:0];
            tick();
            check("sh_result", sh_result, exp[k]);
        end
        sh_valid = 1'b0;
        check("sh_done", {31'h0, sh_done}, 32'h1);
    endtask
    task automatic t_bit();
        logic [2:0] sel [4] = '{3'h1, 3'h0, 3'h7, 3'h6};
        logic [7:0] res [4] = '{8'ha7, 8'ha4, 8'h25, 8'ha5};
        logic       zf [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        bit_byte = 8'ha5;
        bit_valid = 1'b1;
        for (int k = 0; k < 4; k++) begin
            bit_op = k[1:0];
            bit_sel = sel[k];
            tick();
            check("bit_result", {24'h0, bit_result}, {24'h0, res[k]});
            check("bit_zero", {31'h0, bit_zero_flag}, {31'h0, zf[k]});
        end
        bit_valid = 1'b0;
        check("bit_done", {31'h0, bit_done}, 32'h1);
    endtask
    // second pass stalls one cycle, which must delay retirement by one
    task automatic t_retire();
        int n;
        for (int s = 0; s < 2; s++) begin
            issue_valid = 1'b1;
            tick();
            issue_valid = 1'b0;
            stall = s[0];
            n = 1;
            while (retire_valid !== 1'b1 && n < 20) begin
                tick();
                stall = 1'b0;
                n++;
            end
            check("retire_cycles", 32'(n), 32'(5 + s));
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        check("pc_reset", pc_value, 32'h0);
        t_regs();
        t_short();
        t_pc();
        t_shift();
        t_bit();
        t_retire();
        conclude();
    end
    // tests take under 200 cycles; a hang is cut well beyond that
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule // prs_regset_tb_top
